//--- rtl/cag_pkg.sv
// Purpose: shared constants and carriers of the cpu address generation block
// Assumes: 16-bit data space, byte addresses, word-aligned stack
// Notes:   register offsets are byte addresses on a 32-bit apb bus
package cag_pkg;

    // register byte offsets
    localparam logic [11:0] OFF_CIRC_CTRL   = 12'h000;
    localparam logic [11:0] OFF_STACK_LIMIT = 12'h004;
    localparam logic [11:0] OFF_X_START     = 12'h008;
    localparam logic [11:0] OFF_X_END       = 12'h00c;
    localparam logic [11:0] OFF_Y_START     = 12'h010;
    localparam logic [11:0] OFF_Y_END       = 12'h014;

    // circ_addr_control fields
    localparam int          CC_XSEL_LSB  = 0;
    localparam int          CC_YSEL_LSB  = 4;
    localparam int          CC_YEN_BIT   = 14;
    localparam int          CC_XEN_BIT   = 15;
    localparam logic [3:0]  SEL_DISABLED = 4'hf;
    localparam logic [15:0] CC_WMASK     = 16'hc0ff;

    // reset values
    localparam logic [15:0] RST_CIRC_CTRL = 16'h00ff;
    localparam logic [15:0] RST_REG16     = 16'h0000;

    // stack and address constants
    localparam logic [3:0]  STACK_PTR_NUM   = 4'hf;
    localparam logic [15:0] STACK_FLOOR     = 16'h0800;
    localparam logic [15:0] WORD_STEP       = 16'h0002;
    localparam logic [15:0] LSB_CLEAR       = 16'hfffe;
    localparam logic [3:0]  X_PREFETCH_BASE = 4'h8;
    localparam logic [3:0]  Y_PREFETCH_BASE = 4'ha;

    // instruction classes offered to the generator
    typedef enum logic [3:0] {
        OP_FILE_REG  = 4'h0,
        OP_INDIRECT  = 4'h1,
        OP_PUSH      = 4'h2,
        OP_POP       = 4'h3,
        OP_CALL_PUSH = 4'h4,
        OP_EXC_PUSH  = 4'h5,
        OP_DSP       = 4'h6,
        OP_LIT5      = 4'h7,
        OP_BRANCH    = 4'h8,
        OP_INTERRUPT_DISABLE_INSTRUCTION      = 4'h9
    } cag_op_t;

    // indirect modes of mcu and move instructions
    typedef enum logic [2:0] {
        MD_INDIRECT = 3'h0,
        MD_POST_MOD = 3'h1,
        MD_PRE_MOD  = 3'h2,
        MD_INDEXED  = 3'h3,
        MD_LIT_OFF  = 3'h4
    } cag_mode_t;

    // dsp prefetch modes
    typedef enum logic [1:0] {
        DM_INDIRECT = 2'h0,
        DM_POST_MOD = 2'h1,
        DM_INDEXED  = 2'h2
    } cag_dmode_t;

    // one request from the decode stage
    typedef struct packed {
        logic        valid;
        cag_op_t     op;
        cag_mode_t   mode;
        cag_dmode_t  dmode;
        logic [1:0]  dsp_ptr;     // 0..3: x_a, x_b, y_a, y_b
        logic [1:0]  dsp_step;    // post-modify magnitude in words: 1..3
        logic        dec;         // decrement direction
        logic [3:0]  ptr_num;     // pointer register number
        logic [15:0] ptr_val;     // pointer register contents
        logic [15:0] base_val;    // base or offset register contents
        logic [15:0] lit;         // literal field, low bits used per class
        logic [12:0] file_addr;
        logic        to_default_work_register;     // file register result to default work register
        logic [22:0] pc;
        logic [7:0]  status_low_byte;
    } cag_req_t;

    // one registered answer
    typedef struct packed {
        logic        valid;
        logic [15:0] ea;
        logic        wb_en;
        logic [15:0] wb_val;
        logic [15:0] data;        // push word, literal or branch target
        logic        y_space;
        logic        to_default_work_register;
        logic        stack_err;
        logic        illegal;
    } cag_ans_t;

endpackage : cag_pkg

//--- rtl/cag_core.sv
// Purpose: effective address generation, stack checks and circular buffers
// Assumes: requests come from logic on pclk; apb slave answers with no wait state
// Notes:   all outputs are flops of the single state struct
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - stack pointer holds first free word; stack grows upward.
// - pop predecrements stack pointer; push postincrements it.
// - call push clears the top bit of the pushed program counter.
// - exception push places status low byte above program counter high bits.
// - stack limit has no meaningful reset value; bit zero always zero.
// - stack pointer addresses compared with limit; trap only beyond limit.
// - stack pointer address below 0x0800 raises a stack error.
// - file register address is 13 bits; result to register or work register.
// - first mcu operand is a direct register; second may be 5-bit literal.
// - pre-modified mode adjusts pointer first and uses the new value.
// - indexed adds base register; literal-offset mode adds a literal.
// - move source and destination share one 4-bit offset register field.
// - dsp prefetch uses four pointers; first two x space, last two y.
// - dsp indexed mode allowed only for second x and second y pointers.
// - dsp modes are indirect, indexed, and post-modify by 2, 4 or 6.
// - branch uses 16-bit signed literal; interrupt disable uses 14-bit field.
// - one circular buffer in x space and one in y space, any pointer; y buffer here only on prefetch pointers 10 and 11.
// - circular buffers check both lower and upper boundaries.
// - buffer length from start and end; y calculations keep lsb clear.
// - x circular active when select is not 15 and x enable set.
// - y circular active when select is not 15 and y enable set.
module cag_core (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output var  logic [31:0]      prdata,
    output var  logic             pready,
    output var  logic             pslverr,
    input  wire cag_pkg::cag_req_t req,
    output var  cag_pkg::cag_ans_t ans
);

    typedef struct packed {
        logic [15:0]       circ_addr_control;
        logic [15:0]       stack_limit;
        logic [15:0]       x_circ_start;
        logic [15:0]       x_circ_end;
        logic [15:0]       y_circ_start;
        logic [15:0]       y_circ_end;
        logic [31:0]       prdata;
        logic              pready;
        logic              pslverr;
        cag_pkg::cag_ans_t ans;
    } cag_state_t;

    cag_state_t state_reg;
    cag_state_t state_next;

    // true when a byte offset names a mapped register
    function automatic logic cag_mapped(input logic [11:0] a);
        cag_mapped = (a == cag_pkg::OFF_CIRC_CTRL) || (a == cag_pkg::OFF_STACK_LIMIT) ||
                     (a == cag_pkg::OFF_X_START)   || (a == cag_pkg::OFF_X_END) ||
                     (a == cag_pkg::OFF_Y_START)   || (a == cag_pkg::OFF_Y_END);
    endfunction : cag_mapped

    // circular correction: wraps an address that left [start, end]
    function automatic logic [15:0] cag_wrap(input logic [15:0] a,
                                             input logic [15:0] start,
                                             input logic [15:0] stop);
        logic [15:0] len;
        len = 16'(stop - start + 16'h0001);
        // both boundaries checked so power-of-two buffers run either way
        if (a > stop) begin
            cag_wrap = 16'(a - len);
        end else if (a < start) begin
            cag_wrap = 16'(a + len);
        end else begin
            cag_wrap = a;
        end
    endfunction : cag_wrap

    // register read mux, used by the bus read path
    function automatic logic [15:0] cag_read(input cag_state_t s, input logic [11:0] a);
        case (a)
            cag_pkg::OFF_CIRC_CTRL:   cag_read = s.circ_addr_control;
            cag_pkg::OFF_STACK_LIMIT: cag_read = s.stack_limit;
            cag_pkg::OFF_X_START:     cag_read = s.x_circ_start;
            cag_pkg::OFF_X_END:       cag_read = s.x_circ_end;
            cag_pkg::OFF_Y_START:     cag_read = s.y_circ_start;
            cag_pkg::OFF_Y_END:       cag_read = s.y_circ_end;
            default:                  cag_read = 16'h0000;
        endcase
    endfunction : cag_read

    // decoded control fields
    logic [3:0]  x_circ_pointer_select;
    logic [3:0]  y_circ_pointer_select;
    logic        x_circ_enable;
    logic        y_circ_enable;
    logic        x_circ_on;
    logic        y_circ_on;

    assign x_circ_pointer_select = state_reg.circ_addr_control[cag_pkg::CC_XSEL_LSB +: 4];
    assign x_circ_enable         = state_reg.circ_addr_control[cag_pkg::CC_XEN_BIT];
    assign x_circ_on             = x_circ_enable && (x_circ_pointer_select != cag_pkg::SEL_DISABLED);
    assign y_circ_pointer_select = state_reg.circ_addr_control[cag_pkg::CC_YSEL_LSB +: 4];
    assign y_circ_enable         = state_reg.circ_addr_control[cag_pkg::CC_YEN_BIT];
    assign y_circ_on             = y_circ_enable && (y_circ_pointer_select != cag_pkg::SEL_DISABLED);

    // address generation working values
    logic [15:0] step;
    logic [15:0] mod_val;
    logic [15:0] ea;
    logic [15:0] wb_val;
    logic        wb_en;
    logic        use_ptr;
    logic        y_sp;
    logic [3:0]  pnum;
    logic        illegal;

    // effective address formation, before circular correction
    always_comb begin
        step    = cag_pkg::WORD_STEP;
        mod_val = req.ptr_val;
        ea      = req.ptr_val;
        wb_val  = req.ptr_val;
        wb_en   = 1'b0;
        use_ptr = 1'b0;
        y_sp    = 1'b0;
        pnum    = req.ptr_num;
        illegal = 1'b0;
        case (req.op)
            // direct 13-bit field reaches the first 8192 bytes
            cag_pkg::OP_FILE_REG: begin
                ea = {3'b000, req.file_addr};
            end
            // indirect forms, offset register shared by move ends
            cag_pkg::OP_INDIRECT: begin
                use_ptr = 1'b1;
                step    = {11'h000, req.lit[4:0]};
                mod_val = req.dec ? 16'(req.ptr_val - step) : 16'(req.ptr_val + step);
                case (req.mode)
                    cag_pkg::MD_INDIRECT: ea = req.ptr_val;
                    cag_pkg::MD_POST_MOD: begin
                        ea     = req.ptr_val;
                        wb_en  = 1'b1;
                        wb_val = mod_val;
                    end
                    cag_pkg::MD_PRE_MOD: begin
                        ea     = mod_val;
                        wb_en  = 1'b1;
                        wb_val = mod_val;
                    end
                    cag_pkg::MD_INDEXED: ea = 16'(req.ptr_val + req.base_val);
                    cag_pkg::MD_LIT_OFF: ea = 16'(req.ptr_val + req.lit);
                    default:             illegal = 1'b1;
                endcase
            end
            // push writes the free word then advances
            cag_pkg::OP_PUSH, cag_pkg::OP_CALL_PUSH, cag_pkg::OP_EXC_PUSH: begin
                use_ptr = 1'b1;
                pnum    = cag_pkg::STACK_PTR_NUM;
                ea      = req.ptr_val;
                wb_en   = 1'b1;
                wb_val  = 16'(req.ptr_val + cag_pkg::WORD_STEP);
            end
            // pop steps back first, then reads
            cag_pkg::OP_POP: begin
                use_ptr = 1'b1;
                pnum    = cag_pkg::STACK_PTR_NUM;
                ea      = 16'(req.ptr_val - cag_pkg::WORD_STEP);
                wb_en   = 1'b1;
                wb_val  = ea;
            end
            // prefetch pointers fixed to x_a, x_b, y_a, y_b
            cag_pkg::OP_DSP: begin
                use_ptr = 1'b1;
                y_sp    = req.dsp_ptr[1];
                pnum    = y_sp ? 4'(cag_pkg::Y_PREFETCH_BASE + {3'b000, req.dsp_ptr[0]})
                               : 4'(cag_pkg::X_PREFETCH_BASE + {3'b000, req.dsp_ptr[0]});
                // post-modify by 2, 4 or 6 bytes
                step    = {13'h0000, req.dsp_step, 1'b0};
                mod_val = req.dec ? 16'(req.ptr_val - step) : 16'(req.ptr_val + step);
                case (req.dmode)
                    cag_pkg::DM_INDIRECT: ea = req.ptr_val;
                    cag_pkg::DM_POST_MOD: begin
                        ea      = req.ptr_val;
                        wb_en   = 1'b1;
                        wb_val  = mod_val;
                        illegal = (req.dsp_step == 2'b00);
                    end
                    // indexed only through the second pointer of a space
                    cag_pkg::DM_INDEXED: begin
                        ea      = 16'(req.ptr_val + req.base_val);
                        illegal = ~req.dsp_ptr[0];
                    end
                    default: illegal = 1'b1;
                endcase
            end
            cag_pkg::OP_LIT5, cag_pkg::OP_BRANCH, cag_pkg::OP_INTERRUPT_DISABLE_INSTRUCTION: begin
                ea = 16'h0000;
            end
            default: illegal = 1'b1;
        endcase
    end

    // circular correction and stack checks
    logic        x_hit;
    logic        y_hit;
    logic [15:0] ea_fix;
    logic [15:0] wb_fix;
    logic        on_stack;
    logic        stack_err;

    // one buffer per space, selected by pointer number
    assign x_hit = use_ptr && !y_sp && x_circ_on && (pnum == x_circ_pointer_select);
    assign y_hit = use_ptr && y_sp && y_circ_on && (pnum == y_circ_pointer_select);

    always_comb begin
        ea_fix = ea;
        wb_fix = wb_val;
        // wrap both effective address and written-back pointer
        if (x_hit) begin
            ea_fix = cag_wrap(ea, state_reg.x_circ_start, state_reg.x_circ_end);
            wb_fix = cag_wrap(wb_val, state_reg.x_circ_start, state_reg.x_circ_end);
        end else if (y_hit) begin
            // y side works on word data only
            ea_fix = cag_wrap(ea, state_reg.y_circ_start, state_reg.y_circ_end) & cag_pkg::LSB_CLEAR;
            wb_fix = cag_wrap(wb_val, state_reg.y_circ_start, state_reg.y_circ_end) & cag_pkg::LSB_CLEAR;
        end
    end

    // limit and floor checks on any stack-pointer address
    assign on_stack  = use_ptr && (pnum == cag_pkg::STACK_PTR_NUM);
    assign stack_err = on_stack && ((ea_fix > state_reg.stack_limit) || (ea_fix < cag_pkg::STACK_FLOOR));

    // next state: bus slave plus answer register
    always_comb begin
        logic        acc;
        logic [15:0] wd;
        acc        = psel && penable && state_reg.pready;
        wd         = pwdata[15:0];
        state_next = state_reg;

        // apb: ready rises in the access phase, one wait-free answer
        state_next.pready  = psel && !penable;
        state_next.pslverr = psel && !penable && !cag_mapped(paddr);
        if (psel && !penable) begin
            state_next.prdata = {16'h0000, cag_read(state_reg, paddr)};
        end else if (acc) begin
            state_next.prdata = 32'h0000_0000;
        end

        // register writes take effect only at the completing edge
        if (acc && pwrite) begin
            case (paddr)
                cag_pkg::OFF_CIRC_CTRL:   state_next.circ_addr_control = wd & cag_pkg::CC_WMASK;
                // bit zero held at zero for word alignment
                cag_pkg::OFF_STACK_LIMIT: state_next.stack_limit = wd & cag_pkg::LSB_CLEAR;
                cag_pkg::OFF_X_START:     state_next.x_circ_start = wd;
                cag_pkg::OFF_X_END:       state_next.x_circ_end = wd;
                cag_pkg::OFF_Y_START:     state_next.y_circ_start = wd;
                cag_pkg::OFF_Y_END:       state_next.y_circ_end = wd;
                default:                  state_next.stack_limit = state_reg.stack_limit;
            endcase
        end

        // answer, registered one cycle after the request
        state_next.ans.valid     = req.valid;
        state_next.ans.ea        = ea_fix;
        state_next.ans.wb_en     = req.valid && wb_en;
        state_next.ans.wb_val    = wb_fix;
        state_next.ans.y_space   = y_sp;
        state_next.ans.to_default_work_register   = req.to_default_work_register;
        state_next.ans.stack_err = req.valid && stack_err;
        state_next.ans.illegal   = req.valid && illegal;
        case (req.op)
            // call push keeps the upper program counter bit clear
            cag_pkg::OP_CALL_PUSH: state_next.ans.data = {8'h00, 1'b0, req.pc[22:16]};
            // exception push carries the status low byte on top
            cag_pkg::OP_EXC_PUSH:  state_next.ans.data = {req.status_low_byte, 1'b0, req.pc[22:16]};
            cag_pkg::OP_LIT5:      state_next.ans.data = {11'h000, req.lit[4:0]};
            // signed word offset added to the program counter
            cag_pkg::OP_BRANCH:    state_next.ans.data = 16'(req.pc[15:0] + {req.lit[14:0], 1'b0});
            cag_pkg::OP_INTERRUPT_DISABLE_INSTRUCTION:      state_next.ans.data = {2'b00, req.lit[13:0]};
            default:               state_next.ans.data = req.pc[15:0];
        endcase
    end

    // single state register; limit value after reset carries no meaning
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg                   <= '0;
            state_reg.circ_addr_control <= cag_pkg::RST_CIRC_CTRL;
            state_reg.stack_limit       <= cag_pkg::RST_REG16;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the state flops
    assign prdata  = state_reg.prdata;
    assign pready  = state_reg.pready;
    assign pslverr = state_reg.pslverr;
    assign ans     = state_reg.ans;

endmodule : cag_core

`default_nettype wire

//--- bench/cag_core_asserts.sv
// Purpose: concurrent checks on the request and answer ports
// Assumes: one clock, asynchronous active-low reset
// Notes:   stack limit is not visible here, the bench covers it
`timescale 1ns/1ps
`default_nettype none
module cag_core_asserts (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire cag_pkg::cag_req_t req,
    input wire cag_pkg::cag_ans_t ans
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // answer timing, then stack, literal and prefetch relations
    answer_latency_a: assert property (req.valid |=> ans.valid)
        else $error("answer did not follow request");
    push_post_inc_a: assert property (req.valid && req.op == cag_pkg::OP_PUSH |->
        ##1 ans.ea == $past(req.ptr_val) && ans.wb_val == $past(req.ptr_val) + 16'h0002)
        else $error("push address or update wrong");
    pop_pre_dec_a: assert property (req.valid && req.op == cag_pkg::OP_POP |=>
        ans.ea == $past(req.ptr_val) - 16'h0002 && ans.wb_val == ans.ea)
        else $error("pop address or update wrong");
    stack_floor_a: assert property (req.valid && req.ptr_val < 16'h0800 &&
        req.op inside {cag_pkg::OP_PUSH, cag_pkg::OP_CALL_PUSH, cag_pkg::OP_EXC_PUSH}
        |=> ans.stack_err) else $error("underflow not flagged");
    call_push_a: assert property (req.valid && req.op == cag_pkg::OP_CALL_PUSH |=>
        ans.data == {9'h000, $past(req.pc[22:16])}) else $error("call push word wrong");
    exc_push_a: assert property (req.valid && req.op == cag_pkg::OP_EXC_PUSH |=>
        ans.data == {$past(req.status_low_byte), 1'b0, $past(req.pc[22:16])})
        else $error("exception push word wrong");
    branch_target_a: assert property (req.valid && req.op == cag_pkg::OP_BRANCH |=>
        ans.data == $past(req.pc[15:0]) + {$past(req.lit[14:0]), 1'b0}) else $error("branch target wrong");
    dsp_space_a: assert property (req.valid && req.op == cag_pkg::OP_DSP |=>
        ans.y_space == $past(req.dsp_ptr[1])) else $error("prefetch space wrong");
    dsp_index_a: assert property (req.valid && req.op == cag_pkg::OP_DSP &&
        req.dmode == cag_pkg::DM_INDEXED && !req.dsp_ptr[0] |=> ans.illegal)
        else $error("indexed on first pointer accepted");
endmodule : cag_core_asserts

bind cag_core cag_core_asserts i_cag_core_asserts (.pclk(pclk), .presetn(presetn), .req(req), .ans(ans));
`default_nettype wire

//--- bench/cag_core_tb_top.sv
// Purpose: self-checking bench of the address generator
// Assumes: apb answers after one access cycle, answers one cycle after req
// Notes:   random stimulus from a fixed seed mixed with corner values
`timescale 1ns/1ps
`default_nettype none
module cag_core_tb_top;
    logic              pclk;
    logic              presetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [11:0]       paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    cag_pkg::cag_req_t req;
    cag_pkg::cag_ans_t ans;
    cag_pkg::cag_req_t r;
    int                errors;
    int                checks;
    logic [31:0]       q;
    logic              e;
    logic [15:0]       p;
    logic [15:0]       w;
    logic [15:0]       c [8] = '{16'h0ffe, 16'h0800, 16'h0900, 16'h0900, 16'h1000, 16'h0802, 16'h07fe, 16'h0800};
    logic [15:0]       ctl [3] = '{16'h80f3, 16'h00f3, 16'h80ff};
    cag_pkg::cag_op_t  ops [4] = '{cag_pkg::OP_PUSH, cag_pkg::OP_POP, cag_pkg::OP_CALL_PUSH, cag_pkg::OP_EXC_PUSH};

    cag_core i_cag_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .req(req), .ans(ans));

    // 25 MHz clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // watchdog: the whole run needs well under 2000 cycles
    initial begin
        repeat (8000) @(posedge pclk);
        errors++;
        end_of_test();
    end

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk16

    task automatic chkf(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chkf

    // one apb transfer; held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdc(input logic [11:0] a, input logic [15:0] exp, input logic experr);
        apb(1'b0, a, 16'h0000);
        chk16(q[15:0], exp);
        chk16(q[31:16], 16'h0000);
        chkf(e, experr);
    endtask : rdc

    task automatic setr(input cag_pkg::cag_op_t op, input logic [3:0] n, input logic [15:0] v, input logic [15:0] l);
        r         = '0;
        r.valid   = 1'b1;
        r.op      = op;
        r.ptr_num = n;
        r.ptr_val = v;
        r.lit     = l;
    endtask : setr

    // request held one cycle; answer settles one edge later
    task automatic go();
        @(posedge pclk);
        req <= r;
        @(posedge pclk);
        req <= '0;
        #1;
    endtask : go

    function automatic logic [15:0] wrap(input logic [15:0] a, input logic [15:0] s, input logic [15:0] n);
        logic [15:0] len;
        len = n - s + 16'h0001;
        if (a > n) return a - len;
        if (a < s) return a + len;
        return a;
    endfunction : wrap

    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test

    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        req = '0;
        errors = 0;
        checks = 0;
        void'($urandom(32'hec10));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // reset value, write mask, unmapped place
        rdc(cag_pkg::OFF_CIRC_CTRL, 16'h00ff, 1'b0);
        rdc(cag_pkg::OFF_X_END, 16'h0000, 1'b0);
        rdc(12'h018, 16'h0000, 1'b1);
        apb(1'b1, cag_pkg::OFF_CIRC_CTRL, 16'hffff);
        rdc(cag_pkg::OFF_CIRC_CTRL, 16'hc0ff, 1'b0);
        apb(1'b1, cag_pkg::OFF_STACK_LIMIT, 16'h0fff);
        rdc(cag_pkg::OFF_STACK_LIMIT, 16'h0ffe, 1'b0);
        // stack limit, floor and pushed words
        for (int i = 0; i < 40; i++) begin
            p = (i < 8) ? c[i] : 16'h07f0 + 16'(($urandom % 32'h0420) << 1);
            setr(ops[i % 4], 4'hf, p, 16'h0000);
            r.pc = 23'($urandom);
            r.status_low_byte = 8'($urandom);
            go();
            w = (i % 4 == 1) ? p - 16'h0002 : p;
            if (i % 4 < 2) begin
                chk16(ans.ea, w);
                chkf(ans.stack_err, w > 16'h0ffe || w < 16'h0800);
            end else
                chk16(ans.data, {(i % 4 == 3) ? r.status_low_byte : 8'h00, 1'b0, r.pc[22:16]});
        end
        // x buffer wrap, only with enable set and a real select
        apb(1'b1, cag_pkg::OFF_X_START, 16'h1000);
        apb(1'b1, cag_pkg::OFF_X_END, 16'h103f);
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, cag_pkg::OFF_CIRC_CTRL, ctl[k]);
            for (int i = 0; i < 8; i++) begin
                p = 16'h1000 + 16'(($urandom % 32) << 1);
                setr(cag_pkg::OP_INDIRECT, (k == 2) ? 4'hf : 4'h3, p, 16'(($urandom % 4) * 2 + 2));
                r.dec = 1'($urandom);
                r.mode = i[0] ? cag_pkg::MD_PRE_MOD : cag_pkg::MD_POST_MOD;
                go();
                w = r.dec ? p - r.lit : p + r.lit;
                if (k == 0) w = wrap(w, 16'h1000, 16'h103f);
                chk16(ans.wb_val, w);
                chk16(ans.ea, i[0] ? w : p);
                chkf(ans.wb_en, 1'b1);
            end
        end
        // prefetch steps 2, 4, 6 and refused 0, y buffer on pointer 10
        apb(1'b1, cag_pkg::OFF_Y_START, 16'h2000);
        apb(1'b1, cag_pkg::OFF_Y_END, 16'h201f);
        apb(1'b1, cag_pkg::OFF_CIRC_CTRL, 16'h40af);
        for (int s = 0; s < 4; s++)
            for (int d = 0; d < 4; d++) begin
                setr(cag_pkg::OP_DSP, 4'h8 + 4'(d), 16'h201c, 16'h0000);
                r.dmode = cag_pkg::DM_POST_MOD;
                r.dsp_ptr = 2'(d);
                r.dsp_step = 2'(s);
                go();
                w = 16'h201c + 16'(2 * s);
                if (d == 2) w = wrap(w, 16'h2000, 16'h201f);
                chk16(ans.wb_val, w);
                chkf(ans.y_space, d > 1);
                chkf(ans.illegal, s == 0);
            end
        for (int d = 0; d < 4; d++) begin
            setr(cag_pkg::OP_DSP, 4'h8 + 4'(d), 16'h3000, 16'h0000);
            r.dmode = cag_pkg::DM_INDEXED;
            r.dsp_ptr = 2'(d);
            go();
            chkf(ans.illegal, !d[0]);
        end
        setr(cag_pkg::OP_INDIRECT, 4'h2, 16'h1200, 16'h0010);
        r.mode = cag_pkg::MD_INDEXED;
        r.base_val = 16'h0034;
        go();
        chk16(ans.ea, 16'h1234);
        chkf(ans.wb_en, 1'b0);
        r.mode = cag_pkg::MD_LIT_OFF;
        go();
        chk16(ans.ea, 16'h1210);
        r.mode = cag_pkg::MD_INDIRECT;
        go();
        chk16(ans.ea, 16'h1200);
        chkf(ans.wb_en, 1'b0);
        setr(cag_pkg::OP_FILE_REG, 4'h0, 16'h0000, 16'h0000);
        r.file_addr = 13'h1fff;
        r.to_default_work_register = 1'b1;
        go();
        chk16(ans.ea, 16'h1fff);
        chkf(ans.to_default_work_register, 1'b1);
        setr(cag_pkg::OP_INTERRUPT_DISABLE_INSTRUCTION, 4'h0, 16'h0000, 16'hffff);
        go();
        chk16(ans.data, 16'h3fff);
        setr(cag_pkg::OP_LIT5, 4'h0, 16'h0000, 16'hffff);
        go();
        chk16(ans.data, 16'h001f);
        for (int i = 0; i < 8; i++) begin
            setr(cag_pkg::OP_BRANCH, 4'h0, 16'h0000, 16'($urandom));
            r.pc = 23'($urandom);
            go();
            chk16(ans.data, r.pc[15:0] + {r.lit[14:0], 1'b0});
        end
        end_of_test();
    end
endmodule : cag_core_tb_top
`default_nettype wire
